// ==== lvd_ctrl.sv ====
// low-voltage detect control: registers, reset request, crossing irq
`timescale 1ns/1ps
module lvd_ctrl #(
  parameter int FILT_CYC = lvd_pkg::FILT_CYCLES
) (
  // clock and reset (all resets except the detector's own)
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // register bus
  input  wire logic [15:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata,
  // comparator side
  input  wire logic        i_cmp_below,
  output logic             o_cmp_enable,
  output logic             o_use_fixed_ref,
  output logic [3:0]       o_level_code,
  // pin and system
  output logic             o_port12_pin0_oe_n,
  output logic             o_lvd_reset,
  output logic             o_detector_irq
);
  logic       on_reg;
  logic       src_reg;
  logic       mode_reg;
  logic [3:0] level_reg;
  logic [7:0] dir_reg;
  logic       mask_reg;
  logic       req_reg;
  logic       cause_reg;
  logic       below_raw;
  logic       below;
  logic       below_d_reg;
  logic       irq_evt;
  logic       flag;
  logic [lvd_pkg::FILT_CNT_W-1:0] run_reg;

  // one decode shared by reads and writes
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  // filter is cleared while off so the flag reads zero then
  lvd_filter #(.FILT_CYC(FILT_CYC)) u_filt (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_clear     (!on_reg),
    .i_cmp_below (i_cmp_below),
    .o_below_raw (below_raw),
    .o_below     (below)
  );

  assign flag = on_reg & below;

  // control bits: only the outside reset clears them
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_reg   <= lvd_pkg::CTRL_RST[lvd_pkg::CTRL_ON_BIT];
      src_reg  <= lvd_pkg::CTRL_RST[lvd_pkg::CTRL_SRC_BIT];
      mode_reg <= lvd_pkg::CTRL_RST[lvd_pkg::CTRL_MODE_BIT];
    end else if (i_wr && hit(i_addr, lvd_pkg::ADDR_CTRL)) begin
      on_reg   <= i_wdata[lvd_pkg::CTRL_ON_BIT];
      src_reg  <= i_wdata[lvd_pkg::CTRL_SRC_BIT];
      mode_reg <= i_wdata[lvd_pkg::CTRL_MODE_BIT];
    end
  end

  // level code kept through detector reset; upper bits not stored
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_reg <= lvd_pkg::LEVEL_RST;
    end else if (i_wr && hit(i_addr, lvd_pkg::ADDR_LEVEL)) begin
      level_reg <= i_wdata[lvd_pkg::LEVEL_W-1:0];
    end
  end

  // direction and mask return to reset values on every reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_reg  <= lvd_pkg::PORTDIR_RST;
      mask_reg <= 1'b1;
    end else if (o_lvd_reset) begin
      dir_reg  <= lvd_pkg::PORTDIR_RST;
      mask_reg <= 1'b1;
    end else begin
      // only bit 0 steers the pin; the upper bits always read as ones
      if (i_wr && hit(i_addr, lvd_pkg::ADDR_PORTDIR)) begin
        dir_reg <= {lvd_pkg::PORTDIR_RST[7:1], i_wdata[0]};
      end
      if (i_wr && hit(i_addr, lvd_pkg::ADDR_IRQFLG)) begin
        mask_reg <= i_wdata[lvd_pkg::IRQFLG_MSK_BIT];
      end
    end
  end

  // crossing in either direction, or disable while below
  // below lingers only in the cycle after the enable falls, so a
  // switch-off gives exactly one pulse
  assign irq_evt = !mode_reg && !o_lvd_reset &&
                   ((on_reg && (below != below_d_reg)) ||
                    (!on_reg && below));

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      below_d_reg    <= 1'b0;
      o_detector_irq <= 1'b0;
    end else begin
      below_d_reg    <= below;
      o_detector_irq <= irq_evt;
    end
  end

  // request flag: event set wins over a software clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_reg <= 1'b0;
    end else if (irq_evt) begin
      req_reg <= 1'b1;
    end else if (o_lvd_reset) begin
      req_reg <= 1'b0;
    end else if (i_wr && hit(i_addr, lvd_pkg::ADDR_IRQFLG)) begin
      req_reg <= i_wdata[lvd_pkg::IRQFLG_REQ_BIT];
    end
  end

  // internal reset only while below in reset mode, never on entry
  // when already above
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lvd_reset <= 1'b0;
    end else begin
      o_lvd_reset <= on_reg & mode_reg & below;
    end
  end

  // cause bit: set by detector reset, cleared by a read; set wins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause_reg <= 1'b0;
    end else if (o_lvd_reset) begin
      cause_reg <= 1'b1;
    end else if (i_rd && hit(i_addr, lvd_pkg::ADDR_RSTCAU)) begin
      cause_reg <= 1'b0;
    end
  end

  // analogue controls; fixed reference overrides the level code
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmp_enable       <= 1'b0;
      o_use_fixed_ref    <= 1'b0;
      o_level_code       <= lvd_pkg::LEVEL_RST;
      o_port12_pin0_oe_n <= 1'b1;
    end else begin
      o_cmp_enable       <= on_reg;
      o_use_fixed_ref    <= src_reg;
      o_level_code       <= src_reg ? lvd_pkg::LEVEL_RST : level_reg;
      o_port12_pin0_oe_n <= dir_reg[0];
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= 8'h00;
      if (hit(i_addr, lvd_pkg::ADDR_CTRL)) begin
        o_rdata <= {on_reg, 4'h0, src_reg, mode_reg, flag};
      end else if (hit(i_addr, lvd_pkg::ADDR_LEVEL)) begin
        o_rdata <= {4'h0, level_reg};
      end else if (hit(i_addr, lvd_pkg::ADDR_PORTDIR)) begin
        o_rdata <= dir_reg;
      end else if (hit(i_addr, lvd_pkg::ADDR_RSTCAU)) begin
        o_rdata <= {7'h00, cause_reg};
      end else if (hit(i_addr, lvd_pkg::ADDR_IRQFLG)) begin
        o_rdata <= {6'h00, mask_reg, req_reg};
      end
    end
  end

  // helper for the filter check: saturating run of synced-below cycles
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg <= '0;
    end else if (!below_raw) begin
      run_reg <= '0;
    end else if (run_reg != '1) begin
      run_reg <= run_reg + 1'b1;
    end
  end

  // checks
  reset_follows_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (on_reg && mode_reg && below) |=> o_lvd_reset)
    else $error("reset not raised while below in reset mode");
  no_reset_above_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (!below) |=> !o_lvd_reset)
    else $error("reset raised while at or above threshold");
  mask_on_reset_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    o_lvd_reset |=> mask_reg && dir_reg == 8'hff)
    else $error("mask or direction not restored by detector reset");
  cause_set_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    o_lvd_reset |=> cause_reg)
    else $error("reset cause not set");
  level_keep_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (o_lvd_reset && !i_wr) |=> $stable(level_reg) && $stable(on_reg))
    else $error("detector reset disturbed retained bits");
  irq_cross_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (on_reg && !mode_reg && !o_lvd_reset && $rose(below))
      |=> o_detector_irq ##1 req_reg)
    else $error("no irq on falling crossing");
  irq_off_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    ($fell(on_reg) && !mode_reg && below_d_reg && !o_lvd_reset)
      |=> o_detector_irq)
    else $error("no irq when disabled below threshold");
  flag_off_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    !on_reg |-> !flag)
    else $error("flag set while disabled");
  filter_wait_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    $rose(below) |-> run_reg >= FILT_CYC - 1)
    else $error("flag set without sustained below input");
  fixed_ref_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    src_reg |=> o_use_fixed_ref && o_level_code == 4'h0)
    else $error("level code used with external source");
endmodule

// ==== lvd_pkg.sv ====
// shared constants for the low-voltage detect control block
package lvd_pkg;
  // bus addresses
  localparam logic [15:0] ADDR_CTRL    = 16'hffbe;
  localparam logic [15:0] ADDR_LEVEL   = 16'hffbf;
  localparam logic [15:0] ADDR_PORTDIR = 16'hff2c;
  localparam logic [15:0] ADDR_RSTCAU  = 16'hffa8;
  localparam logic [15:0] ADDR_IRQFLG  = 16'hffe0;
  // control register fields
  localparam int CTRL_ON_BIT   = 7;
  localparam int CTRL_SRC_BIT  = 2;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_FLAG_BIT = 0;
  // level select field
  localparam int LEVEL_W = 4;
  // reset cause and irq flag fields
  localparam int RSTCAU_LVD_BIT = 0;
  localparam int IRQFLG_REQ_BIT = 0;
  localparam int IRQFLG_MSK_BIT = 1;
  // reset values
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [3:0] LEVEL_RST   = 4'h0;
  localparam logic [7:0] PORTDIR_RST = 8'hff;
  // timing: clock period and least below-level pulse width
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILT_TIME_NS  = 200_000;
  localparam int FILT_CYCLES   =
    (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W    = 16;
endpackage

// ==== lvd_filter.sv ====
// comparator synchroniser and minimum-width below-level filter
`timescale 1ns/1ps
module lvd_filter #(
  parameter int FILT_CYC = lvd_pkg::FILT_CYCLES
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_clear,
  // comparator
  input  wire logic i_cmp_below,
  // result
  output logic      o_below_raw,
  output logic      o_below
);
  logic                            sync1_reg;
  logic                            sync2_reg;
  logic [lvd_pkg::FILT_CNT_W-1:0]  cnt_reg;
  logic [lvd_pkg::FILT_CNT_W-1:0]  cnt_next;
  logic                            below_next;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= i_cmp_below;
      sync2_reg <= sync1_reg;
    end
  end

  // count below time; flag only after the full pulse width
  always_comb begin
    cnt_next   = cnt_reg;
    below_next = o_below;
    if (i_clear || !sync2_reg) begin
      cnt_next   = '0;
      below_next = 1'b0;
    end else if (cnt_reg < FILT_CYC[lvd_pkg::FILT_CNT_W-1:0] - 1'b1) begin
      cnt_next = cnt_reg + 1'b1;
    end else begin
      below_next = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg     <= '0;
      o_below     <= 1'b0;
      o_below_raw <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      o_below     <= below_next;
      o_below_raw <= sync2_reg;
    end
  end
endmodule

// ==== lvd_cmp_model.sv ====
// behavioural comparator for the supply and the external sense pin
`timescale 1ns/1ps
module lvd_cmp_model (
  // clock
  input  wire logic        i_core_clk,
  // control from the detector
  input  wire logic        i_en,
  input  wire logic        i_fixed,
  input  wire logic [3:0]  i_code,
  // analogue levels in millivolts
  input  wire logic [15:0] i_supply_mv,
  input  wire logic [15:0] i_pin_mv,
  // comparator result, high = below threshold
  output logic             o_below
);
  // thresholds in mV, code 0 highest, falling with the code
  logic [15:0] thr_mv [16] = '{16'h1090, 16'h0FFA, 16'h0F5A, 16'h0EC4,
    16'h0E24, 16'h0D8E, 16'h0CF8, 16'h0C58, 16'h0BC2, 16'h0B22,
    16'h0A8C, 16'h09F6, 16'h0956, 16'h08C0, 16'h0820, 16'h078A};
  logic        churn = 1'b0;
  // an idle comparator says nothing, so its output churns every cycle
  always @(negedge i_core_clk) churn <= ~churn;
  // fixed 1.21 V reference ignores the level code
  assign o_below = !i_en ? churn :
                   i_fixed ? (i_pin_mv < 16'h04BA) :
                   (i_supply_mv < thr_mv[i_code]);
endmodule

// ==== tb.sv ====
// self-checking bench for the low-voltage detect control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("Error %s expected %h seen %h", nm, exp, got); \
  end end
module tb;
  // design and model wiring
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_cmp_below;
  logic [7:0]  o_rdata;
  logic [3:0]  o_level_code;
  logic        o_cmp_enable, o_use_fixed_ref, o_port12_pin0_oe_n;
  logic        o_lvd_reset, o_detector_irq;
  logic [15:0] supply_mv = 16'h1388;
  logic [15:0] pin_mv = 16'h07D0;
  int          n_mismatch = 0, total_checks = 0;
  int          n_irq = 0, n_rst = 0, cyc = 0;
  // short filter keeps the run brief
  lvd_ctrl #(.FILT_CYC(8)) lvd_ctrl_i (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_cmp_below(i_cmp_below),
    .o_cmp_enable(o_cmp_enable), .o_use_fixed_ref(o_use_fixed_ref),
    .o_level_code(o_level_code), .o_port12_pin0_oe_n(o_port12_pin0_oe_n),
    .o_lvd_reset(o_lvd_reset), .o_detector_irq(o_detector_irq));
  lvd_cmp_model lvd_cmp_model_i (.i_core_clk(i_core_clk),
    .i_en(o_cmp_enable), .i_fixed(o_use_fixed_ref), .i_code(o_level_code),
    .i_supply_mv(supply_mv), .i_pin_mv(pin_mv), .o_below(i_cmp_below));
  initial forever #10 i_core_clk = ~i_core_clk;
  // event counters and run ceiling; a hang ends as a mismatch
  always @(posedge i_core_clk) begin
    if (o_detector_irq === 1'b1) n_irq++;
    if (o_lvd_reset === 1'b1) n_rst++;
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cw(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // one-cycle strobes, held across the sampling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_core_clk);
    i_wr = 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [15:0] a,
                     input logic [7:0] exp);
    @(negedge i_core_clk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_core_clk);
    i_rd = 1'b0;
    `CHK(nm, exp, o_rdata)
  endtask
  task automatic t_reset();
    cw(20);
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h00);
    rdc("level", lvd_pkg::ADDR_LEVEL, 8'h00);
    rdc("dir", lvd_pkg::ADDR_PORTDIR, 8'hFF);
    rdc("irqflg", lvd_pkg::ADDR_IRQFLG, 8'h02);
    rdc("cause", lvd_pkg::ADDR_RSTCAU, 8'h00);
    rdc("unmapped", 16'h1234, 8'h00);
    `CHK("oe_n", 1'b1, o_port12_pin0_oe_n)
    `CHK("irqs", 0, n_irq)
  endtask
  task automatic t_fields();
    for (int c = 0; c < 16; c++) begin
      wr(lvd_pkg::ADDR_LEVEL, 8'(c));
      cw(1);
      `CHK("level_code", 4'(c), o_level_code)
    end
    wr(lvd_pkg::ADDR_LEVEL, 8'h03);
    wr(lvd_pkg::ADDR_CTRL, 8'h06);
    cw(1);
    `CHK("fixed_ref", 1'b1, o_use_fixed_ref)
    `CHK("level_code", 4'h0, o_level_code)
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h06);
    `CHK("reset", 1'b0, o_lvd_reset)
    wr(lvd_pkg::ADDR_CTRL, 8'h00);
    rdc("level", lvd_pkg::ADDR_LEVEL, 8'h03);
  endtask
  // supply crossings in interrupt mode, then switch-off while below
  task automatic t_irq();
    wr(lvd_pkg::ADDR_CTRL, 8'h80);
    cw(10);
    `CHK("enable", 1'b1, o_cmp_enable)
    n_irq = 0;
    supply_mv = 16'h0E74;
    cw(4);
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h80);
    cw(15);
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h81);
    `CHK("irqs", 1, n_irq)
    rdc("irqflg", lvd_pkg::ADDR_IRQFLG, 8'h03);
    supply_mv = 16'h1388;
    cw(10);
    `CHK("irqs", 2, n_irq)
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h80);
    supply_mv = 16'h0E74;
    cw(20);
    wr(lvd_pkg::ADDR_CTRL, 8'h00);
    cw(5);
    `CHK("irqs", 4, n_irq)
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h00);
  endtask
  // external pin against the fixed reference; supply is below its level
  task automatic t_ext();
    wr(lvd_pkg::ADDR_PORTDIR, 8'hFF);
    wr(lvd_pkg::ADDR_IRQFLG, 8'h02);
    wr(lvd_pkg::ADDR_CTRL, 8'h84);
    cw(500);
    n_irq = 0;
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h84);
    pin_mv = 16'h03E8;
    cw(20);
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h85);
    pin_mv = 16'h07D0;
    cw(10);
    `CHK("irqs", 2, n_irq)
    // then reset mode on the pin, stopped by the two-step procedure
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h84);
    n_rst = 0;
    wr(lvd_pkg::ADDR_CTRL, 8'h86);
    cw(5);
    `CHK("resets", 0, n_rst)
    pin_mv = 16'h03E8;
    cw(20);
    `CHK("reset", 1'b1, o_lvd_reset)
    pin_mv = 16'h07D0;
    cw(10);
    `CHK("reset", 1'b0, o_lvd_reset)
    rdc("cause", lvd_pkg::ADDR_RSTCAU, 8'h01);
    wr(lvd_pkg::ADDR_CTRL, 8'h84);
    wr(lvd_pkg::ADDR_CTRL, 8'h00);
    `CHK("irqs", 2, n_irq)
    supply_mv = 16'h1388;
  endtask
  // supply reset mode, started in the order software must keep
  task automatic t_rstmode();
    wr(lvd_pkg::ADDR_LEVEL, 8'h03);
    wr(lvd_pkg::ADDR_PORTDIR, 8'h00);
    rdc("dir", lvd_pkg::ADDR_PORTDIR, 8'hFE);
    wr(lvd_pkg::ADDR_IRQFLG, 8'h02);
    wr(lvd_pkg::ADDR_CTRL, 8'h80);
    cw(500);
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h80);
    n_rst = 0;
    wr(lvd_pkg::ADDR_CTRL, 8'h82);
    cw(20);
    `CHK("resets", 0, n_rst)
    `CHK("oe_n", 1'b0, o_port12_pin0_oe_n)
    // unmask after start-up so the detector reset must set it again
    wr(lvd_pkg::ADDR_IRQFLG, 8'h00);
    supply_mv = 16'h0E74;
    cw(20);
    `CHK("reset", 1'b1, o_lvd_reset)
    `CHK("level_code", 4'h3, o_level_code)
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h83);
    supply_mv = 16'h1388;
    cw(10);
    `CHK("reset", 1'b0, o_lvd_reset)
    rdc("cause", lvd_pkg::ADDR_RSTCAU, 8'h01);
    rdc("cause", lvd_pkg::ADDR_RSTCAU, 8'h00);
    rdc("dir", lvd_pkg::ADDR_PORTDIR, 8'hFF);
    rdc("irqflg", lvd_pkg::ADDR_IRQFLG, 8'h02);
    rdc("level", lvd_pkg::ADDR_LEVEL, 8'h03);
    wr(lvd_pkg::ADDR_CTRL, 8'h00);
    cw(3);
    `CHK("enable", 1'b0, o_cmp_enable)
  endtask
  // a second outside reset in mid-run clears what a detector reset keeps
  task automatic t_rst2();
    wr(lvd_pkg::ADDR_CTRL, 8'h80);
    wr(lvd_pkg::ADDR_IRQFLG, 8'h00);
    wr(lvd_pkg::ADDR_PORTDIR, 8'h00);
    cw(1);
    `CHK("oe_n", 1'b0, o_port12_pin0_oe_n)
    i_rst_n = 1'b0;
    cw(2);
    `CHK("oe_n", 1'b1, o_port12_pin0_oe_n)
    i_rst_n = 1'b1;
    rdc("ctrl", lvd_pkg::ADDR_CTRL, 8'h00);
    rdc("level", lvd_pkg::ADDR_LEVEL, 8'h00);
    rdc("irqflg", lvd_pkg::ADDR_IRQFLG, 8'h02);
    rdc("dir", lvd_pkg::ADDR_PORTDIR, 8'hFF);
  endtask
  initial begin
    repeat (12) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_fields();
    t_irq();
    t_ext();
    t_rstmode();
    t_rst2();
    give_verdict();
  end
endmodule
